// [src/msc_regbank.sv]
// msc_regbank: channel-disable configuration and two status registers of a
// temperature/voltage monitor, plus the channel sequencer that they steer.
// assumes: a serial protocol engine presents byte commands on CMD_*; a read
// is latched at CMD_RD_STB and its side effect applied at CMD_RD_DONE. The
// converter reports per-channel results as one-cycle strobes on CLOCK; diode
// fault and over-temperature compare levels arrive from analog and are synced.
`timescale 1ns/1ps

module msc_regbank
  import msc_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_CYCLES,
  parameter int unsigned IDLE_CYC = IDLE_CYCLES
) (
  input  wire logic                CLOCK,
  input  wire logic                RST_N,
  input  wire logic                CE,
  input  wire logic                CMD_WR_STB,
  input  wire logic                CMD_RD_STB,
  input  wire logic                CMD_RD_DONE,
  input  wire logic [7:0]          CMD_CODE,
  input  wire logic [7:0]          CMD_WDATA,
  output logic      [7:0]          CMD_RDATA,
  output logic                     CMD_RVALID,
  input  wire logic                STANDBY,
  input  wire logic                MASK_REMOTE_ONE,
  input  wire logic                MASK_REMOTE_TWO,
  output logic                     CONV_START,
  output logic      [2:0]          CONV_CHANNEL,
  input  wire logic                CONV_DONE,
  input  wire logic                RESULT_HIGH,
  input  wire logic                RESULT_LOW,
  input  wire logic [2:0]          DIODE_FAULT_ASYNC,
  input  wire logic [2:0]          OVERTEMP_ASYNC,
  output logic                     ALERT_EVENT,
  output logic      [2:0]          OVERTEMP_SHUTDOWN_OUTPUT
);

  typedef struct packed {
    msc_seq_state_t     st;
    logic [TMR_W-1:0]   tmr;
    logic [2:0]         ch;
    logic [7:0]         cfg;
    logic [7:0]         rdata;
    logic               rvalid;
    logic               clr1;
    logic               clr2;
    logic               fault1;
    logic               fault2;
    logic [2:0]         ot;
    logic               alert;
    logic               start;
  } msc_regbank_t;

  msc_regbank_t s_q;
  msc_regbank_t s_d;

  logic [2:0]  fault_sync;
  logic [2:0]  ot_sync;
  logic [9:0]  evt_set;
  logic [9:0]  evt_flag;
  logic [9:0]  evt_clr;
  logic [7:0]  st1_val;
  logic [7:0]  st2_val;
  logic [NUM_CH-1:0] ch_off;
  logic [2:0]  next_ch;
  logic        any_on;
  logic        busy;
  logic        conv_ok;

  msc_sync #(
    .W (3)
  ) u_fault_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .ce    (CE),
    .din   (DIODE_FAULT_ASYNC),
    .dout  (fault_sync)
  );

  msc_sync #(
    .W (3)
  ) u_ot_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .ce    (CE),
    .din   (OVERTEMP_ASYNC),
    .dout  (ot_sync)
  );

  // channel order: rem1, rem2, local, voltage_input_three, voltage_input_two, voltage_input_one, supply
  always_comb begin
    ch_off[CH_REM1]   = s_q.cfg[CFG_REM1_BIT];
    ch_off[CH_REM2]   = s_q.cfg[CFG_REM2_BIT];
    ch_off[CH_LOCAL]  = s_q.cfg[CFG_LOCAL_BIT];
    ch_off[CH_VOLTAGE_INPUT_THREE]   = s_q.cfg[CFG_VOLTAGE_INPUT_THREE_BIT];
    ch_off[CH_VOLTAGE_INPUT_TWO]   = s_q.cfg[CFG_VOLTAGE_INPUT_TWO_BIT];
    ch_off[CH_VOLTAGE_INPUT_ONE]   = s_q.cfg[CFG_VOLTAGE_INPUT_ONE_BIT];
    ch_off[CH_SUPPLY] = s_q.cfg[CFG_SUPPLY_BIT];
  end

  // next enabled channel after the current one, wrapping
  always_comb begin
    logic [2:0] c;
    c      = s_q.ch;
    next_ch = s_q.ch;
    any_on = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      c = (c == CH_LAST) ? CH_REM1 : 3'(c + 3'h1);
      if (!any_on && !ch_off[c]) begin
        next_ch = c;
        any_on  = 1'b1;
      end
    end
  end

  assign busy = (s_q.st == MSC_CONV);
  // a result from a channel disabled mid-conversion is dropped
  assign conv_ok = busy && CONV_DONE && !ch_off[s_q.ch];

  // latched event sources: 0..5 temperature limits, 6..9 voltage windows
  always_comb begin
    evt_set = '0;
    if (conv_ok) begin
      unique case (s_q.ch)
        CH_LOCAL: begin
          evt_set[0] = RESULT_HIGH;
          evt_set[1] = RESULT_LOW;
        end
        CH_REM1: begin
          evt_set[2] = RESULT_HIGH;
          evt_set[3] = RESULT_LOW;
        end
        CH_REM2: begin
          evt_set[4] = RESULT_HIGH;
          evt_set[5] = RESULT_LOW;
        end
        CH_VOLTAGE_INPUT_THREE:   evt_set[6] = RESULT_HIGH | RESULT_LOW;
        CH_VOLTAGE_INPUT_TWO:   evt_set[7] = RESULT_HIGH | RESULT_LOW;
        CH_VOLTAGE_INPUT_ONE:   evt_set[8] = RESULT_HIGH | RESULT_LOW;
        CH_SUPPLY: evt_set[9] = RESULT_HIGH | RESULT_LOW;
        default: evt_set = '0;
      endcase
    end
  end

  // clear only what the finished read reported, so later trips survive
  always_comb begin
    evt_clr[0] = s_q.clr1 & s_q.rdata[ST1_LOCAL_HIGH_FLAG_BIT];
    evt_clr[1] = s_q.clr1 & s_q.rdata[ST1_LOCAL_LOW_FLAG_BIT];
    evt_clr[2] = s_q.clr1 & s_q.rdata[ST1_R1HIGH_BIT];
    evt_clr[3] = s_q.clr1 & s_q.rdata[ST1_R1LOW_BIT];
    evt_clr[4] = s_q.clr1 & s_q.rdata[ST1_REMOTE_TWO_HIGH_FLAG_BIT];
    evt_clr[5] = s_q.clr1 & s_q.rdata[ST1_REMOTE_TWO_LOW_FLAG_BIT];
    evt_clr[6] = s_q.clr2 & s_q.rdata[ST2_V3_BIT];
    evt_clr[7] = s_q.clr2 & s_q.rdata[ST2_V2_BIT];
    evt_clr[8] = s_q.clr2 & s_q.rdata[ST2_V1_BIT];
    evt_clr[9] = s_q.clr2 & s_q.rdata[ST2_VCC_BIT];
  end

  for (genvar g = 0; g < 10; g++) begin : g_flag
    msc_sticky u_flag (
      .clk   (CLOCK),
      .rst_n (RST_N),
      .ce    (CE),
      .set   (evt_set[g]),
      .clr   (evt_clr[g]),
      .flag  (evt_flag[g])
    );
  end

  always_comb begin
    st1_val                 = STATUS_RESET;
    st1_val[ST1_BUSY_BIT]   = busy;
    st1_val[ST1_LOCAL_HIGH_FLAG_BIT]  = evt_flag[0];
    st1_val[ST1_LOCAL_LOW_FLAG_BIT]   = evt_flag[1];
    st1_val[ST1_R1HIGH_BIT] = evt_flag[2];
    st1_val[ST1_R1LOW_BIT]  = evt_flag[3];
    st1_val[ST1_R1FLT_BIT]  = s_q.fault1;
    st1_val[ST1_REMOTE_TWO_HIGH_FLAG_BIT] = evt_flag[4];
    st1_val[ST1_REMOTE_TWO_LOW_FLAG_BIT]  = evt_flag[5];
    st2_val                 = STATUS_RESET;
    st2_val[ST2_LOT_BIT]    = s_q.ot[0];
    st2_val[ST2_R1OT_BIT]   = s_q.ot[1];
    st2_val[ST2_R2OT_BIT]   = s_q.ot[2];
    st2_val[ST2_R2FLT_BIT]  = s_q.fault2;
    st2_val[ST2_V3_BIT]     = evt_flag[6];
    st2_val[ST2_V2_BIT]     = evt_flag[7];
    st2_val[ST2_V1_BIT]     = evt_flag[8];
    st2_val[ST2_VCC_BIT]    = evt_flag[9];
  end

  always_comb begin
    s_d        = s_q;
    s_d.start  = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.clr1   = 1'b0;
    s_d.clr2   = 1'b0;
    s_d.alert  = 1'b0;

    // register write; reserved bit stays zero
    if (CMD_WR_STB && CMD_CODE == CMD_WR_CFG2) begin
      s_d.cfg = CMD_WDATA & CFG2_WRITE_MSK;
    end

    // snapshot at the read, clear once the transfer completes
    if (CMD_RD_STB) begin
      s_d.rvalid = 1'b1;
      unique case (CMD_CODE)
        CMD_RD_TEMP_STATUS: s_d.rdata = st1_val;
        CMD_RD_OTV_STATUS:  s_d.rdata = st2_val;
        CMD_RD_CFG2:        s_d.rdata = s_q.cfg;
        default:            s_d.rdata = BYTE_ZERO;
      endcase
    end
    if (CMD_RD_DONE && CMD_CODE == CMD_RD_TEMP_STATUS) begin
      s_d.clr1 = 1'b1;
    end
    if (CMD_RD_DONE && CMD_CODE == CMD_RD_OTV_STATUS) begin
      s_d.clr2 = 1'b1;
    end

    // fault and over-temperature levels only for enabled remote/local channels
    s_d.fault1 = fault_sync[0] & ~ch_off[CH_REM1];
    s_d.fault2 = fault_sync[1] & ~ch_off[CH_REM2];
    s_d.ot[0]  = ot_sync[0] & ~ch_off[CH_LOCAL];
    s_d.ot[1]  = ot_sync[1] & ~ch_off[CH_REM1];
    s_d.ot[2]  = ot_sync[2] & ~ch_off[CH_REM2];

    // alert events: remote masks suppress their diode's trips
    s_d.alert = |evt_set[5:0] & ~((evt_set[2] | evt_set[3]) & MASK_REMOTE_ONE
                                  & ~|evt_set[1:0] & ~|evt_set[5:4])
              & ~((evt_set[4] | evt_set[5]) & MASK_REMOTE_TWO
                  & ~|evt_set[3:0]);
    s_d.alert = s_d.alert | (|evt_set[9:6]);

    unique case (s_q.st)
      MSC_IDLE: begin
        if (s_q.tmr != '0) begin
          s_d.tmr = TMR_W'(s_q.tmr - 1'b1);
        end else if (!STANDBY) begin
          s_d.st = MSC_PICK;
        end
      end
      MSC_PICK: begin
        if (any_on) begin
          s_d.ch    = next_ch;
          s_d.st    = MSC_CONV;
          s_d.start = 1'b1;
          s_d.tmr   = TMR_W'(CONV_CYC);
        end else begin
          s_d.st  = MSC_IDLE;
          s_d.tmr = TMR_W'(IDLE_CYC);
        end
      end
      MSC_CONV: begin
        if (s_q.tmr != '0) begin
          s_d.tmr = TMR_W'(s_q.tmr - 1'b1);
        end
        if (CONV_DONE || s_q.tmr == '0 || STANDBY) begin
          s_d.st  = MSC_IDLE;
          s_d.tmr = (next_ch <= s_q.ch) ? TMR_W'(IDLE_CYC) : '0;
        end
      end
      default: s_d.st = MSC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_q     <= '0;
      s_q.ch  <= CH_LAST;  // first pick wraps to remote one
      s_q.st  <= MSC_PICK;
      s_q.cfg <= CFG2_RESET;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign CMD_RDATA    = s_q.rdata;
  assign CMD_RVALID   = s_q.rvalid;
  assign CONV_START   = s_q.start;
  assign CONV_CHANNEL = s_q.ch;
  assign ALERT_EVENT  = s_q.alert;
  // remote masks also hold off the shutdown output
  assign OVERTEMP_SHUTDOWN_OUTPUT = s_q.ot & {~MASK_REMOTE_TWO, ~MASK_REMOTE_ONE, 1'b1};

endmodule

// [include/msc_pkg.sv]
// msc_pkg: register indices, bit positions, reset values and sequencer types
// for the monitor channel-disable and status register bank.
// assumes: one 100 MHz clock; registers reached through a byte-wide command port.
package msc_pkg;

  localparam int unsigned NUM_CH = 7;

  // command codes of the three registers
  localparam logic [7:0] CMD_RD_TEMP_STATUS = 8'h02;
  localparam logic [7:0] CMD_RD_OTV_STATUS  = 8'h32;
  localparam logic [7:0] CMD_RD_CFG2        = 8'h33;
  localparam logic [7:0] CMD_WR_CFG2        = 8'h34;

  localparam logic [7:0] CFG2_RESET     = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] CFG2_WRITE_MSK = 8'hFE;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;

  // channel index, also the sequence order
  localparam logic [2:0] CH_REM1  = 3'h0;
  localparam logic [2:0] CH_REM2  = 3'h1;
  localparam logic [2:0] CH_LOCAL = 3'h2;
  localparam logic [2:0] CH_VOLTAGE_INPUT_THREE  = 3'h3;
  localparam logic [2:0] CH_VOLTAGE_INPUT_TWO  = 3'h4;
  localparam logic [2:0] CH_VOLTAGE_INPUT_ONE  = 3'h5;
  localparam logic [2:0] CH_SUPPLY = 3'h6;
  localparam logic [2:0] CH_LAST  = 3'h6;

  // channel disable bits
  localparam int unsigned CFG_REM1_BIT   = 7;
  localparam int unsigned CFG_REM2_BIT   = 6;
  localparam int unsigned CFG_LOCAL_BIT  = 5;
  localparam int unsigned CFG_VOLTAGE_INPUT_THREE_BIT   = 4;
  localparam int unsigned CFG_VOLTAGE_INPUT_TWO_BIT   = 3;
  localparam int unsigned CFG_VOLTAGE_INPUT_ONE_BIT   = 2;
  localparam int unsigned CFG_SUPPLY_BIT = 1;

  // temperature status bits
  localparam int unsigned ST1_BUSY_BIT   = 7;
  localparam int unsigned ST1_LOCAL_HIGH_FLAG_BIT  = 6;
  localparam int unsigned ST1_LOCAL_LOW_FLAG_BIT   = 5;
  localparam int unsigned ST1_R1HIGH_BIT = 4;
  localparam int unsigned ST1_R1LOW_BIT  = 3;
  localparam int unsigned ST1_R1FLT_BIT  = 2;
  localparam int unsigned ST1_REMOTE_TWO_HIGH_FLAG_BIT = 1;
  localparam int unsigned ST1_REMOTE_TWO_LOW_FLAG_BIT  = 0;

  // over-temperature / voltage status bits
  localparam int unsigned ST2_LOT_BIT  = 7;
  localparam int unsigned ST2_R1OT_BIT = 6;
  localparam int unsigned ST2_R2OT_BIT = 5;
  localparam int unsigned ST2_R2FLT_BIT = 4;
  localparam int unsigned ST2_V3_BIT   = 3;
  localparam int unsigned ST2_V2_BIT   = 2;
  localparam int unsigned ST2_V1_BIT   = 1;
  localparam int unsigned ST2_VCC_BIT  = 0;

  // conversion and idle times
  localparam int unsigned CONV_TIME_NS = 1000;
  localparam int unsigned IDLE_TIME_NS = 2000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDLE_CYCLES = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 16;

  typedef enum logic [1:0] {
    MSC_IDLE  = 2'b00,
    MSC_PICK  = 2'b01,
    MSC_CONV  = 2'b10
  } msc_seq_state_t;

endpackage

// [src/msc_sticky.sv]
// msc_sticky: one latched event flag, cleared by a read-completion pulse.
// assumes: set and clear are single-clock-domain strobes.
`timescale 1ns/1ps
module msc_sticky
  import msc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } msc_sticky_t;

  msc_sticky_t s_q;
  msc_sticky_t s_d;

  always_comb begin
    s_d = s_q;
    // a set in the clearing cycle survives
    if (set) begin
      s_d.flag = 1'b1;
    end else if (clr) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;

endmodule

// [src/msc_sync.sv]
// msc_sync: three-stage synchroniser for an asynchronous level; the output
// moves only when the second and third stages agree.
// assumes: input may change at any time relative to clk.
`timescale 1ns/1ps
module msc_sync
  import msc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } msc_sync_t;

  msc_sync_t s_q;
  msc_sync_t s_d;

  always_comb begin
    s_d     = s_q;
    s_d.s1  = din;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.out[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;

endmodule

// [tb/msc_regbank_props.sv]
// msc_regbank_props: timing checks on the register port and sequencer outputs.
// assumes: bound to msc_regbank, CE held high, one clock domain.
`timescale 1ns/1ps
module msc_regbank_props
  import msc_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       RST_N,
  input wire logic       CMD_WR_STB,
  input wire logic       CMD_RD_STB,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_WDATA,
  input wire logic [7:0] CMD_RDATA,
  input wire logic       CMD_RVALID,
  input wire logic       MASK_REMOTE_ONE,
  input wire logic       MASK_REMOTE_TWO,
  input wire logic       CONV_START,
  input wire logic [2:0] CONV_CHANNEL,
  input wire logic       CONV_DONE,
  input wire logic [2:0] OVERTEMP_ASYNC,
  input wire logic       ALERT_EVENT,
  input wire logic [2:0] OVERTEMP_SHUTDOWN_OUTPUT
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_p;

  // shadow of the disable register; cfg_p is what the sequencer saw last cycle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= CFG2_RESET;
      cfg_p <= CFG2_RESET;
    end else begin
      cfg_p <= cfg_q;
      if (CMD_WR_STB && CMD_CODE == CMD_WR_CFG2) begin
        cfg_q <= CMD_WDATA & CFG2_WRITE_MSK;
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_rvalid_follows: assert property (CMD_RD_STB |=> CMD_RVALID)
    else $error("read answer missing");
  a_rvalid_single: assert property (!CMD_RD_STB |=> !CMD_RVALID)
    else $error("read answer without request");
  a_rdata_holds: assert property (!CMD_RVALID |-> $stable(CMD_RDATA))
    else $error("read data moved without answer");
  a_cfg_readback: assert property (CMD_RD_STB && CMD_CODE == CMD_RD_CFG2 && !CMD_WR_STB
    |=> CMD_RDATA == $past(cfg_q)) else $error("disable register readback wrong");
  a_start_enabled: assert property (CONV_START
    |-> CONV_CHANNEL <= CH_LAST && !cfg_p[3'h7 - CONV_CHANNEL])
    else $error("disabled channel converted");
  a_start_pulse: assert property (CONV_START |=> !CONV_START)
    else $error("start longer than one cycle");
  a_alert_cause: assert property (ALERT_EVENT |-> $past(CONV_DONE))
    else $error("alert without result");
  a_mask_one: assert property (MASK_REMOTE_ONE && $past(MASK_REMOTE_ONE)
    |-> !OVERTEMP_SHUTDOWN_OUTPUT[1]) else $error("masked remote one shutdown");
  a_mask_two: assert property (MASK_REMOTE_TWO && $past(MASK_REMOTE_TWO)
    |-> !OVERTEMP_SHUTDOWN_OUTPUT[2]) else $error("masked remote two shutdown");
  a_ot_clears: assert property ((OVERTEMP_ASYNC[0] == 1'b0)[*6]
    |-> !OVERTEMP_SHUTDOWN_OUTPUT[0]) else $error("local shutdown stuck");

  c_supply: cover property (CONV_START && CONV_CHANNEL == CH_SUPPLY);
  c_status_read: cover property (CMD_RD_STB && CMD_CODE == CMD_RD_TEMP_STATUS);
  c_alert: cover property (ALERT_EVENT);
endmodule

// [tb/msc_conv_model.sv]
// msc_conv_model: converter answering each start with a result strobe.
// assumes: start is a one-cycle pulse; trip vectors are indexed by channel.
`timescale 1ns/1ps
module msc_conv_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [2:0] ch,
  input  wire logic [6:0] trip_hi,
  input  wire logic [6:0] trip_lo,
  output logic            done,
  output logic            res_high,
  output logic            res_low
);
  logic [1:0] cnt_q;
  logic [2:0] ch_q;
  logic       busy_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 2'h0;
      ch_q   <= 3'h0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= 2'h0;
        ch_q   <= ch;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == 2'h1) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

  // result levels are only valid with done; otherwise show the opposite
  assign res_high = done ? trip_hi[ch_q] : ~trip_hi[ch_q];
  assign res_low  = done ? trip_lo[ch_q] : ~trip_lo[ch_q];
endmodule

// [tb/test_msc_regbank.sv]
// test_msc_regbank: register-port tests of the disable and status bank.
// assumes: msc_conv_model stands in for the converter; shortened counts.
`timescale 1ns/1ps
module test_msc_regbank
  import msc_pkg::*;
;
  logic       CLOCK, RST_N, CMD_WR_STB, CMD_RD_STB, CMD_RD_DONE, CMD_RVALID;
  logic       MASK_REMOTE_ONE, MASK_REMOTE_TWO, CONV_START, CONV_DONE;
  logic       RESULT_HIGH, RESULT_LOW, ALERT_EVENT;
  logic [7:0] CMD_CODE, CMD_WDATA, CMD_RDATA, d;
  logic [2:0] CONV_CHANNEL, DIODE_FAULT_ASYNC, OVERTEMP_ASYNC, OVERTEMP_SHUTDOWN_OUTPUT, ch;
  logic [6:0] trip_hi, trip_lo;
  int         errors, checked, nstart, nalert;
  logic       cnt_clr;
  logic [7:0] e1 [8] = '{8'h10, 8'h02, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
  logic [7:0] e2 [8] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};

  msc_regbank #(.CONV_CYC(4), .IDLE_CYC(8)) i_msc_regbank (
    .CLOCK(CLOCK), .RST_N(RST_N), .CE(1'b1), .CMD_WR_STB(CMD_WR_STB),
    .CMD_RD_STB(CMD_RD_STB), .CMD_RD_DONE(CMD_RD_DONE), .CMD_CODE(CMD_CODE),
    .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
    .STANDBY(1'b0), .MASK_REMOTE_ONE(MASK_REMOTE_ONE), .MASK_REMOTE_TWO(MASK_REMOTE_TWO),
    .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE),
    .RESULT_HIGH(RESULT_HIGH), .RESULT_LOW(RESULT_LOW),
    .DIODE_FAULT_ASYNC(DIODE_FAULT_ASYNC), .OVERTEMP_ASYNC(OVERTEMP_ASYNC),
    .ALERT_EVENT(ALERT_EVENT), .OVERTEMP_SHUTDOWN_OUTPUT(OVERTEMP_SHUTDOWN_OUTPUT));

  msc_conv_model i_msc_conv_model (
    .clk(CLOCK), .rst_n(RST_N), .start(CONV_START), .ch(CONV_CHANNEL), .trip_hi(trip_hi),
    .trip_lo(trip_lo), .done(CONV_DONE), .res_high(RESULT_HIGH), .res_low(RESULT_LOW));

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // counts start and alert pulses since the last clr_counts
  always @(posedge CLOCK) begin
    if (cnt_clr) begin
      nstart <= 0;
      nalert <= 0;
    end else begin
      if (CONV_START === 1'b1) begin
        nstart <= nstart + 1;
      end
      if (ALERT_EVENT === 1'b1) begin
        nalert <= nalert + 1;
      end
    end
  end

  task automatic clr_counts;
    cnt_clr <= 1'b1;
    @(posedge CLOCK);
    cnt_clr <= 1'b0;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] v);
    @(posedge CLOCK);
    CMD_CODE   <= CMD_WR_CFG2;
    CMD_WDATA  <= v;
    CMD_WR_STB <= 1'b1;
    @(posedge CLOCK);
    CMD_WR_STB <= 1'b0;
  endtask

  // request, answer one edge later, then completion with the code held
  task automatic rd(input logic [7:0] code, output logic [7:0] v);
    @(posedge CLOCK);
    CMD_CODE   <= code;
    CMD_RD_STB <= 1'b1;
    @(posedge CLOCK);
    CMD_RD_STB <= 1'b0;
    @(posedge CLOCK);
    v = (CMD_RVALID === 1'b1) ? CMD_RDATA : 8'hXX;
    CMD_RD_DONE <= 1'b1;
    @(posedge CLOCK);
    CMD_RD_DONE <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLOCK);
    errors++;
    report_and_stop();
  end

  initial begin
    {RST_N, CMD_WR_STB, CMD_RD_STB, CMD_RD_DONE, MASK_REMOTE_ONE, MASK_REMOTE_TWO} = '0;
    {CMD_CODE, CMD_WDATA, DIODE_FAULT_ASYNC, OVERTEMP_ASYNC, trip_hi, trip_lo} = '0;
    {errors, checked} = '0;
    cnt_clr = 1'b0;
    repeat (8) @(posedge CLOCK);
    RST_N <= 1'b1;
    // edge that sees the first start pulse; the read lands mid-conversion
    @(posedge CLOCK iff CONV_START === 1'b1);
    rd(CMD_RD_TEMP_STATUS, d);
    check(d, 8'h80);
    rd(CMD_RD_OTV_STATUS, d);
    check(d, STATUS_RESET);
    rd(CMD_RD_CFG2, d);
    check(d, CFG2_RESET);
    wr(8'hFF);
    rd(CMD_RD_CFG2, d);
    check(d, 8'hFE);
    repeat (20) @(posedge CLOCK);
    clr_counts();
    repeat (40) @(posedge CLOCK);
    check(nstart[7:0], 8'h00);
    rd(CMD_RD_TEMP_STATUS, d);
    check(d & 8'h80, 8'h00);
    // one channel enabled at a time, every channel tripping
    for (int k = 0; k < 8; k++) begin
      ch = (k == 7) ? 3'h2 : 3'(k);
      wr(8'hFE & ~(8'h80 >> ch));
      repeat (30) @(posedge CLOCK);
      rd(CMD_RD_TEMP_STATUS, d);
      rd(CMD_RD_OTV_STATUS, d);
      trip_hi <= (k == 7) ? 7'h00 : 7'h7F;
      trip_lo <= (k == 7) ? 7'h7F : 7'h00;
      repeat (30) @(posedge CLOCK);
      trip_hi <= '0;
      trip_lo <= '0;
      repeat (10) @(posedge CLOCK);
      rd(CMD_RD_TEMP_STATUS, d);
      check(d & 8'h7F, e1[k]);
      rd(CMD_RD_OTV_STATUS, d);
      check(d, e2[k]);
      rd(CMD_RD_TEMP_STATUS, d);
      check(d & 8'h7F, 8'h00);
      rd(CMD_RD_OTV_STATUS, d);
      check(d, 8'h00);
    end
    // remote one alone, tripping high: the mask holds off alerts, not flags
    wr(8'h7E);
    MASK_REMOTE_ONE <= 1'b1;
    trip_hi <= 7'h7F;
    clr_counts();
    repeat (30) @(posedge CLOCK);
    check(nalert[7:0], 8'h00);
    rd(CMD_RD_TEMP_STATUS, d);
    check(d & 8'h7F, 8'h10);
    MASK_REMOTE_ONE <= 1'b0;
    clr_counts();
    repeat (30) @(posedge CLOCK);
    check({7'h00, nalert != 0}, 8'h01);
    trip_hi <= '0;
    wr(8'h00);
    DIODE_FAULT_ASYNC <= 3'b011;
    OVERTEMP_ASYNC <= 3'b111;
    repeat (20) @(posedge CLOCK);
    rd(CMD_RD_TEMP_STATUS, d);
    check(d & 8'h04, 8'h04);
    rd(CMD_RD_OTV_STATUS, d);
    check(d & 8'hF0, 8'hF0);
    rd(CMD_RD_OTV_STATUS, d);
    check(d & 8'hE0, 8'hE0);
    check({5'h00, OVERTEMP_SHUTDOWN_OUTPUT}, 8'h07);
    MASK_REMOTE_ONE <= 1'b1;
    MASK_REMOTE_TWO <= 1'b1;
    repeat (3) @(posedge CLOCK);
    check({5'h00, OVERTEMP_SHUTDOWN_OUTPUT}, 8'h01);
    {DIODE_FAULT_ASYNC, OVERTEMP_ASYNC, MASK_REMOTE_ONE, MASK_REMOTE_TWO} <= '0;
    repeat (10) @(posedge CLOCK);
    rd(CMD_RD_OTV_STATUS, d);
    check(d & 8'hF0, 8'h00);
    report_and_stop();
  end
endmodule

bind msc_regbank msc_regbank_props i_msc_regbank_props (
  .CLOCK(CLOCK), .RST_N(RST_N), .CMD_WR_STB(CMD_WR_STB), .CMD_RD_STB(CMD_RD_STB),
  .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
  .MASK_REMOTE_ONE(MASK_REMOTE_ONE), .MASK_REMOTE_TWO(MASK_REMOTE_TWO),
  .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE),
  .OVERTEMP_ASYNC(OVERTEMP_ASYNC), .ALERT_EVENT(ALERT_EVENT),
  .OVERTEMP_SHUTDOWN_OUTPUT(OVERTEMP_SHUTDOWN_OUTPUT));
